// ==== verilog/olsr_pkg.sv ====
`default_nettype none
package olsr_pkg;
  // register offsets
  localparam logic [7:0] OLSR_OFF_SHADOW = 8'h4f;
  localparam logic [7:0] OLSR_OFF_LST1 = 8'h50;
  localparam logic [7:0] OLSR_OFF_LST2 = 8'h51;
  localparam logic [7:0] OLSR_OFF_LVEND0 = 8'h52;
  localparam logic [7:0] OLSR_OFF_LVEND1 = 8'h53;
  localparam logic [7:0] OLSR_OFF_LVEND2 = 8'h54;
  localparam logic [7:0] OLSR_OFF_LMODEL0 = 8'h55;
  localparam logic [7:0] OLSR_OFF_LMODEL1 = 8'h56;
  localparam logic [7:0] OLSR_OFF_LMODEL2 = 8'h57;
  localparam logic [7:0] OLSR_OFF_PST1 = 8'h58;
  localparam logic [7:0] OLSR_OFF_PST2 = 8'h59;
  localparam logic [7:0] OLSR_OFF_PVEND0 = 8'h5a;
  localparam logic [7:0] OLSR_OFF_PVEND1 = 8'h5b;
  localparam logic [7:0] OLSR_OFF_PVEND2 = 8'h5c;
  localparam logic [7:0] OLSR_OFF_PMODEL0 = 8'h5d;
  localparam logic [7:0] OLSR_OFF_PMODEL1 = 8'h5e;
  localparam logic [7:0] OLSR_OFF_PMODEL2 = 8'h5f;
  // first status byte fields
  localparam int OLSR_B_ROLE = 6;
  localparam int OLSR_B_LOOP = 5;
  localparam int OLSR_B_LOSSEL = 4;
  localparam int OLSR_B_DIAG = 3;
  localparam int OLSR_B_TPDOWN = 2;
  localparam int OLSR_B_OPTABS = 1;
  localparam int OLSR_B_PWRDN = 0;
  // second status byte fields
  localparam int OLSR_B_MULTI = 3;
  localparam int OLSR_B_AUTONEG = 2;
  localparam int OLSR_B_DUPLEX = 1;
  localparam int OLSR_B_SPEED = 0;
  // strap and status pin indices in the synchroniser vector
  localparam int OLSR_P_ROLE = 0;
  localparam int OLSR_P_LOSSEL = 1;
  localparam int OLSR_P_DIAG = 2;
  localparam int OLSR_P_PWRDN_N = 3;
  localparam int OLSR_P_AUTONEG = 4;
  localparam int OLSR_NPINS = 5;
  // reset values
  localparam logic [7:0] OLSR_LST1_RST = 8'h06;
  localparam logic [7:0] OLSR_LST2_RST = 8'h00;
  localparam logic [7:0] OLSR_PST1_CENTER = 8'h47;
  localparam logic [7:0] OLSR_PST1_TERM = 8'h07;
  localparam logic [7:0] OLSR_BYTE_RST = 8'h00;
  localparam logic [23:0] OLSR_WORD_RST = 24'h000000;
  // writable masks of the two status bytes per role
  localparam logic [7:0] OLSR_LST1_WMASK_CENTER = 8'h1c;
  localparam logic [7:0] OLSR_LST2_WMASK_CENTER = 8'h08;
  localparam logic [7:0] OLSR_LST2_WMASK_TERM = 8'h0c;
  // edges after reset release before straps are trusted
  localparam logic [2:0] OLSR_INIT_LAST = 3'h4;
endpackage : olsr_pkg
`default_nettype wire

// ==== verilog/olsr_regs.sv ====
// Notes on behaviour
// - bit 6 of status one is read-only role: 1 terminal, 0 center.
// - bit 5 of status one reads 1 in any loopback state, else 0.
// - bit 4 of status one picks fault indication (1) or frame (0).
// - terminal side: bit 4 follows the selection pin level.
// - bit 3 diag fail; resets to pin; terminal tracks pin, center writes.
// - bit 2 twisted pair down, reset 1; terminal hardware, center writes.
// - bit 1 reads 1 without optical signal, reset 1.
// - bit 0 power down, reset to inverse of active-low pin.
// - bit 3 of status two: writable multiple interface flag, reset 0.
// - bit 2 of status two: autoneg strap on terminal; center kept 0.
// - terminal bit 1 full duplex, 0 if half or link down; center 0.
// - terminal bit 0 100Mbps, 0 if 10Mbps or link down; center 0.
// - upper four bits of status two read zero.
// - writable 24-bit local vendor field at 0x52..0x54, reset zero.
// - writable 24-bit local model field at 0x55..0x57, reset zero.
// - partner status one read-only; resets 0x47 center, 0x07 terminal.
// - partner status two read-only, reset zero.
// - partner vendor and model bytes 0x5a..0x5f read-only, reset zero.
// - shadow register mirrors partner status one while optics up.
// - extended mode maps model bytes onto remote command bytes.
`default_nettype none
module olsr_regs
  import olsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // strap and status pins, asynchronous
  input wire logic media_converter_role,
  input wire logic los_select_pin,
  input wire logic diag_fail_pin,
  input wire logic powerdown_pin_n,
  input wire logic autoneg_strap_pin,
  // local link state from core logic
  input wire logic center_loop_state_a,
  input wire logic center_loop_state_b,
  input wire logic terminal_loop_state,
  input wire logic tp_link_down,
  input wire logic tp_full_duplex,
  input wire logic tp_speed_100,
  input wire logic optical_signal_detect,
  input wire logic optical_link_up,
  // remote command bytes and mode
  input wire logic extended_mode,
  input wire logic [7:0] remote_cmd_byte0,
  input wire logic [7:0] remote_cmd_byte1,
  input wire logic [7:0] remote_cmd_byte2,
  // received maintenance frame fields
  input wire logic frame_valid,
  input wire logic [7:0] frame_status_one,
  input wire logic [7:0] frame_status_two,
  input wire logic [23:0] frame_vendor,
  input wire logic [23:0] frame_model,
  // local fields towards the frame builder
  output logic [7:0] local_status_one,
  output logic [7:0] local_status_two,
  output logic [23:0] local_vendor_bits,
  output logic [23:0] local_model_bits,
  output logic los_notify_select,
  output logic init_done
);
  import olsr_pkg::*;

  typedef struct packed {
    logic [2:0] init_cnt;
    logic init_done;
    logic role_term;
    logic [OLSR_NPINS-1:0] sy1;
    logic [OLSR_NPINS-1:0] sy2;
    logic [OLSR_NPINS-1:0] sy3;
    logic [OLSR_NPINS-1:0] pins;
    logic [7:0] lst1;
    logic [7:0] lst2;
    logic [23:0] lvend;
    logic [23:0] lmodel;
    logic [7:0] pst1;
    logic [7:0] pst2;
    logic [23:0] pvend;
    logic [23:0] pmodel;
    logic [7:0] shadow;
    logic [7:0] rdata;
    logic rvalid;
  } olsr_state_t;

  olsr_state_t state_ff;
  olsr_state_t nxt_state;
  logic [OLSR_NPINS-1:0] pin_bus;
  logic [7:0] wmask1;
  logic [7:0] wmask2;
  logic [7:0] rd_mux;

  assign pin_bus = {autoneg_strap_pin, powerdown_pin_n, diag_fail_pin,
                    los_select_pin, media_converter_role};

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rvalid = 1'b0;
    // first stage feeds only the second
    nxt_state.sy1 = pin_bus;
    nxt_state.sy2 = state_ff.sy1;
    nxt_state.sy3 = state_ff.sy2;
    // a pin change counts once stages two and three agree
    nxt_state.pins = (state_ff.sy2 & state_ff.sy3) |
                     (state_ff.pins & (state_ff.sy2 ^ state_ff.sy3));
    wmask1 = state_ff.role_term ? OLSR_BYTE_RST : OLSR_LST1_WMASK_CENTER;
    wmask2 = state_ff.role_term ? OLSR_LST2_WMASK_TERM
                                : OLSR_LST2_WMASK_CENTER;

    if (!state_ff.init_done) begin
      // straps are caught once the filter has settled after release
      nxt_state.init_cnt = state_ff.init_cnt + 3'h1;
      if (state_ff.init_cnt == OLSR_INIT_LAST) begin
        nxt_state.init_done = 1'b1;
        nxt_state.role_term = state_ff.pins[OLSR_P_ROLE];
        // role bit shows with init_done, so no cycle reads center by mistake
        nxt_state.lst1[OLSR_B_ROLE] = state_ff.pins[OLSR_P_ROLE];
        nxt_state.lst1[OLSR_B_DIAG] = state_ff.pins[OLSR_P_DIAG];
        nxt_state.lst1[OLSR_B_PWRDN] =
          ~state_ff.pins[OLSR_P_PWRDN_N];
        nxt_state.lst2[OLSR_B_AUTONEG] = state_ff.pins[OLSR_P_ROLE] &
          state_ff.pins[OLSR_P_AUTONEG];
        nxt_state.pst1 = state_ff.pins[OLSR_P_ROLE] ? OLSR_PST1_TERM
                                                    : OLSR_PST1_CENTER;
        nxt_state.shadow = nxt_state.pst1;
      end
    end else begin
      // software writes; read-only bits are masked off
      if (reg_wr) begin
        unique case (reg_addr)
          OLSR_OFF_LST1: nxt_state.lst1 =
            (state_ff.lst1 & ~wmask1) | (reg_wdata & wmask1);
          OLSR_OFF_LST2: nxt_state.lst2 =
            (state_ff.lst2 & ~wmask2) | (reg_wdata & wmask2);
          OLSR_OFF_LVEND0: nxt_state.lvend[7:0] = reg_wdata;
          OLSR_OFF_LVEND1: nxt_state.lvend[15:8] = reg_wdata;
          OLSR_OFF_LVEND2: nxt_state.lvend[23:16] = reg_wdata;
          OLSR_OFF_LMODEL0: nxt_state.lmodel[7:0] = reg_wdata;
          OLSR_OFF_LMODEL1: nxt_state.lmodel[15:8] = reg_wdata;
          OLSR_OFF_LMODEL2: nxt_state.lmodel[23:16] = reg_wdata;
          default: ;
        endcase
      end
      // hardware owned bits override any write in the same cycle
      nxt_state.lst1[7] = 1'b0;
      nxt_state.lst1[OLSR_B_ROLE] = state_ff.role_term;
      nxt_state.lst1[OLSR_B_LOOP] = center_loop_state_a |
        center_loop_state_b | terminal_loop_state;
      nxt_state.lst1[OLSR_B_OPTABS] = ~optical_signal_detect;
      nxt_state.lst1[OLSR_B_PWRDN] =
        ~state_ff.pins[OLSR_P_PWRDN_N];
      if (state_ff.role_term) begin
        nxt_state.lst1[OLSR_B_LOSSEL] =
          state_ff.pins[OLSR_P_LOSSEL];
        nxt_state.lst1[OLSR_B_DIAG] = state_ff.pins[OLSR_P_DIAG];
        nxt_state.lst1[OLSR_B_TPDOWN] = tp_link_down;
        nxt_state.lst2[OLSR_B_DUPLEX] =
          tp_full_duplex & ~tp_link_down;
        nxt_state.lst2[OLSR_B_SPEED] =
          tp_speed_100 & ~tp_link_down;
      end else begin
        nxt_state.lst2[OLSR_B_AUTONEG] = 1'b0;
        nxt_state.lst2[OLSR_B_DUPLEX] = 1'b0;
        nxt_state.lst2[OLSR_B_SPEED] = 1'b0;
      end
      nxt_state.lst2[7:4] = 4'h0;
      if (frame_valid) begin
        nxt_state.pst1 = frame_status_one;
        nxt_state.pst2 = frame_status_two;
        nxt_state.pvend = frame_vendor;
        nxt_state.pmodel = frame_model;
      end
      if (optical_link_up) begin
        nxt_state.shadow = nxt_state.pst1;
      end
    end

    // read data sampled in the request cycle, answered next edge
    case (reg_addr)
      OLSR_OFF_SHADOW: rd_mux = state_ff.shadow;
      OLSR_OFF_LST1: rd_mux = state_ff.lst1;
      OLSR_OFF_LST2: rd_mux = state_ff.lst2;
      OLSR_OFF_LVEND0: rd_mux = state_ff.lvend[7:0];
      OLSR_OFF_LVEND1: rd_mux = state_ff.lvend[15:8];
      OLSR_OFF_LVEND2: rd_mux = state_ff.lvend[23:16];
      OLSR_OFF_LMODEL0: rd_mux = extended_mode ? remote_cmd_byte0
                                               : state_ff.lmodel[7:0];
      OLSR_OFF_LMODEL1: rd_mux = extended_mode ? remote_cmd_byte1
                                               : state_ff.lmodel[15:8];
      OLSR_OFF_LMODEL2: rd_mux = extended_mode ? remote_cmd_byte2
                                               : state_ff.lmodel[23:16];
      OLSR_OFF_PST1: rd_mux = state_ff.pst1;
      OLSR_OFF_PST2: rd_mux = state_ff.pst2;
      OLSR_OFF_PVEND0: rd_mux = state_ff.pvend[7:0];
      OLSR_OFF_PVEND1: rd_mux = state_ff.pvend[15:8];
      OLSR_OFF_PVEND2: rd_mux = state_ff.pvend[23:16];
      OLSR_OFF_PMODEL0: rd_mux = state_ff.pmodel[7:0];
      OLSR_OFF_PMODEL1: rd_mux = state_ff.pmodel[15:8];
      OLSR_OFF_PMODEL2: rd_mux = state_ff.pmodel[23:16];
      default: rd_mux = OLSR_BYTE_RST;
    endcase
    if (reg_rd) begin
      nxt_state.rdata = rd_mux;
      nxt_state.rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff.init_cnt <= 3'h0;
      state_ff.init_done <= 1'b0;
      state_ff.role_term <= 1'b0;
      state_ff.sy1 <= '0;
      state_ff.sy2 <= '0;
      state_ff.sy3 <= '0;
      state_ff.pins <= '0;
      state_ff.lst1 <= OLSR_LST1_RST;
      state_ff.lst2 <= OLSR_LST2_RST;
      state_ff.lvend <= OLSR_WORD_RST;
      state_ff.lmodel <= OLSR_WORD_RST;
      state_ff.pst1 <= OLSR_PST1_TERM;
      state_ff.pst2 <= OLSR_BYTE_RST;
      state_ff.pvend <= OLSR_WORD_RST;
      state_ff.pmodel <= OLSR_WORD_RST;
      state_ff.shadow <= OLSR_PST1_TERM;
      state_ff.rdata <= OLSR_BYTE_RST;
      state_ff.rvalid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign reg_rvalid = state_ff.rvalid;
  assign local_status_one = state_ff.lst1;
  assign local_status_two = state_ff.lst2;
  assign local_vendor_bits = state_ff.lvend;
  assign local_model_bits = state_ff.lmodel;
  assign los_notify_select = state_ff.lst1[OLSR_B_LOSSEL];
  assign init_done = state_ff.init_done;
endmodule : olsr_regs
`default_nettype wire

// ==== bench/olsr_far_end.sv ====
`default_nettype none
module olsr_far_end (
  // clock
  input wire logic clk,
  // frame request from the bench
  input wire logic send,
  input wire logic [7:0] base,
  // maintenance frame fields
  output logic frame_valid,
  output logic [7:0] frame_status_one,
  output logic [7:0] frame_status_two,
  output logic [23:0] frame_vendor,
  output logic [23:0] frame_model
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] s_ff;
  always_ff @(posedge clk) begin
    frame_valid <= send;
    s_ff <= base;
  end
  // fields inverted outside the pulse so a late capture is caught
  assign frame_status_one = {8{~frame_valid}} ^ s_ff;
  assign frame_status_two = {8{~frame_valid}} ^ (s_ff + 8'h01);
  assign frame_vendor = {24{~frame_valid}} ^
    {s_ff + 8'h04, s_ff + 8'h03, s_ff + 8'h02};
  assign frame_model = {24{~frame_valid}} ^
    {s_ff + 8'h07, s_ff + 8'h06, s_ff + 8'h05};
endmodule : olsr_far_end
`default_nettype wire

// ==== bench/olsr_properties.sv ====
`default_nettype none
module olsr_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins and link state
  input wire logic los_select_pin,
  input wire logic powerdown_pin_n,
  input wire logic center_loop_state_a,
  input wire logic center_loop_state_b,
  input wire logic terminal_loop_state,
  input wire logic tp_link_down,
  input wire logic optical_signal_detect,
  // register port
  input wire logic reg_wr,
  // bank outputs
  input wire logic [7:0] local_status_one,
  input wire logic [7:0] local_status_two,
  input wire logic los_notify_select,
  input wire logic init_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic term;
  logic loop_any;
  logic center_sw;
  assign center_sw = init_done && !local_status_one[6];
  assign term = init_done && local_status_one[6];
  assign loop_any = center_loop_state_a | center_loop_state_b |
    terminal_loop_state;
  sequence loop_held;
    (init_done && loop_any) [*3];
  endsequence
  a_loop_flag_set: assert property (loop_held |-> local_status_one[5])
    else $error("loop flag low");
  a_loop_flag_clr: assert property ((init_done && !loop_any) [*3] |->
    !local_status_one[5]) else $error("loop flag high");
  a_optical_flag: assert property ((init_done && optical_signal_detect) [*3]
    |-> !local_status_one[1]) else $error("optical flag wrong");
  a_tp_hw_down: assert property ((term && tp_link_down) [*3]
    |-> local_status_one[2]) else $error("tp down not shown");
  a_speed_gated: assert property ((init_done && tp_link_down) [*3]
    |-> local_status_two[1:0] == 2'h0) else $error("speed not gated");
  a_center_zero: assert property (init_done && !local_status_one[6]
    |-> local_status_two[2:0] == 3'h0) else $error("center bits set");
  a_upper_zero: assert property (local_status_two[7:4] == 4'h0)
    else $error("reserved bits set");
  a_los_sw_only: assert property (center_sw && !$past(reg_wr)
    |-> $stable(los_notify_select)) else $error("los select moved unwritten");
  a_los_pin: assert property ((term && los_select_pin) [*7]
    |-> los_notify_select) else $error("los pin ignored");
  a_pwr_pin: assert property ((init_done && !powerdown_pin_n) [*7]
    |-> local_status_one[0]) else $error("power down missed");
endmodule : olsr_properties
bind olsr_regs olsr_properties i_olsr_properties (.clk(clk), .nrst(nrst),
  .los_select_pin(los_select_pin), .powerdown_pin_n(powerdown_pin_n),
  .center_loop_state_a(center_loop_state_a),
  .center_loop_state_b(center_loop_state_b),
  .terminal_loop_state(terminal_loop_state), .tp_link_down(tp_link_down),
  .optical_signal_detect(optical_signal_detect), .reg_wr(reg_wr),
  .local_status_one(local_status_one), .local_status_two(local_status_two),
  .los_notify_select(los_notify_select), .init_done(init_done));
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
  import olsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, wr, rd, rv, role, lsel, diag, pwr_n, aneg, init, los;
  logic la, lb, lt, tpd, fdx, s100, osd, olu, ext, send, fvld;
  logic [7:0] addr, wdata, rdata, c0, c1, c2, base, fs1, fs2, ls1, ls2;
  logic [23:0] fv, fm, lv, lm;
  int err_count, n_checks;
  olsr_regs i_olsr_regs (.clk(clk), .nrst(nrst), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rv), .media_converter_role(role), .los_select_pin(lsel),
    .diag_fail_pin(diag), .powerdown_pin_n(pwr_n), .autoneg_strap_pin(aneg),
    .center_loop_state_a(la), .center_loop_state_b(lb),
    .terminal_loop_state(lt), .tp_link_down(tpd), .tp_full_duplex(fdx),
    .tp_speed_100(s100), .optical_signal_detect(osd), .optical_link_up(olu),
    .extended_mode(ext), .remote_cmd_byte0(c0), .remote_cmd_byte1(c1),
    .remote_cmd_byte2(c2), .frame_valid(fvld), .frame_status_one(fs1),
    .frame_status_two(fs2), .frame_vendor(fv), .frame_model(fm),
    .local_status_one(ls1), .local_status_two(ls2), .local_vendor_bits(lv),
    .local_model_bits(lm), .los_notify_select(los), .init_done(init));
  olsr_far_end i_olsr_far_end (.clk(clk), .send(send), .base(base),
    .frame_valid(fvld), .frame_status_one(fs1), .frame_status_two(fs2),
    .frame_vendor(fv), .frame_model(fm));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // answer stands one cycle; look mid-cycle, hand back on an edge
    @(negedge clk);
    chk({7'h00, rv}, 8'h01);
    chk(rdata, exp);
    @(posedge clk);
  endtask : rd_chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic restart(input logic r);
    nrst <= 1'b0;
    role <= r;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 20 && init !== 1'b1; i++) @(posedge clk);
    chk({7'h00, init}, 8'h01);
  endtask : restart
  // 0x4f up to 0x60; the last entry is unmapped
  task automatic scan(input logic [7:0] img [18]);
    for (int i = 0; i < 18; i++) rd_chk(8'h4f + 8'(i), img[i]);
  endtask : scan
  task automatic frame(input logic [7:0] s, input logic up);
    @(posedge clk);
    olu <= up;
    base <= s;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(8'h58 + 8'(i), s + 8'(i));
  endtask : frame
  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
  initial begin
    {wr, rd, la, lb, lt, fdx, s100, osd, olu, ext, send, lsel, diag} = '0;
    {tpd, pwr_n, aneg, nrst} = 4'hf;
    {addr, wdata, c0, c1, c2, base} = '0;
    err_count = 0;
    n_checks = 0;
    restart(1'b1);
    scan('{0: 8'h07, 1: 8'h46, 2: 8'h04, 9: 8'h07, default: 8'h00});
    wr_reg(OLSR_OFF_LST1, 8'hff);
    rd_chk(OLSR_OFF_LST1, 8'h46);
    wr_reg(OLSR_OFF_LST2, 8'hff);
    rd_chk(OLSR_OFF_LST2, 8'h0c);
    wr_reg(OLSR_OFF_PST1, 8'h00);
    rd_chk(OLSR_OFF_PST1, 8'h07);
    for (int i = 0; i < 6; i++) wr_reg(8'h52 + 8'(i), 8'ha0 + 8'(i));
    for (int i = 0; i < 6; i++) rd_chk(8'h52 + 8'(i), 8'ha0 + 8'(i));
    chk(lv[7:0], 8'ha0);
    chk(lv[23:16], 8'ha2);
    chk(lm[7:0], 8'ha3);
    chk(lm[23:16], 8'ha5);
    @(posedge clk);
    ext <= 1'b1;
    {c2, c1, c0} <= 24'h442211;
    for (int i = 0; i < 3; i++) rd_chk(8'h55 + 8'(i), 8'h11 << i);
    ext <= 1'b0;
    rd_chk(OLSR_OFF_LMODEL0, 8'ha3);
    // pins need the synchroniser and filter before they show
    {la, tpd, fdx, s100, osd, lsel, diag, pwr_n} <= 8'hbe;
    repeat (8) @(posedge clk);
    rd_chk(OLSR_OFF_LST1, 8'h79);
    rd_chk(OLSR_OFF_LST2, 8'h0f);
    chk({7'h00, los}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      {la, lb, lt} <= 3'h4 >> i;
      rd_chk(OLSR_OFF_LST1, 8'h79);
    end
    {la, lb, lt, tpd} <= 4'h1;
    rd_chk(OLSR_OFF_LST2, 8'h0c);
    rd_chk(OLSR_OFF_LST1, 8'h5d);
    frame(8'h30, 1'b1);
    rd_chk(OLSR_OFF_SHADOW, 8'h30);
    frame(8'h80, 1'b0);
    rd_chk(OLSR_OFF_SHADOW, 8'h30);
    restart(1'b0);
    scan('{0: 8'h47, 1: 8'h0d, 9: 8'h47, default: 8'h00});
    wr_reg(OLSR_OFF_LST1, 8'hff);
    rd_chk(OLSR_OFF_LST1, 8'h1d);
    chk({7'h00, los}, 8'h01);
    wr_reg(OLSR_OFF_LST1, 8'h00);
    rd_chk(OLSR_OFF_LST1, 8'h01);
    wr_reg(OLSR_OFF_LST2, 8'hff);
    rd_chk(OLSR_OFF_LST2, 8'h08);
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
